// ===== rtl/tvi_pkg.sv
// Package of constants shared by the two-source vectored interrupt unit.
package tvi_pkg;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int          REG_W         = 8;
  localparam int          ADDR_W        = 2;
  localparam logic [1:0]  ADDR_INTC     = 2'h0;
  localparam logic [1:0]  ADDR_SYSCTL2  = 2'h1;
  localparam logic [7:0]  INTC_RESET    = 8'h00;
  localparam logic [7:0]  SYSCTL2_RESET = 8'h00;
  localparam logic [7:0]  INTC_MASK     = 8'h37;
  localparam logic [7:0]  SYSCTL2_MASK  = 8'hc0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_PIN_EN    = 1;
  localparam int BIT_TIMER_EN  = 2;
  localparam int BIT_PIN_FLAG  = 4;
  localparam int BIT_TIMER_FLAG = 5;
  localparam int BIT_EDGE_LOW  = 6;
  localparam int BIT_EDGE_HIGH = 7;

  // ---------------------------------------------------------------
  // Pin trigger selection
  // ---------------------------------------------------------------
  localparam logic [1:0] EDGE_OFF     = 2'h0;
  localparam logic [1:0] EDGE_RISING  = 2'h1;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  // ---------------------------------------------------------------
  // Program counter and vectors
  // ---------------------------------------------------------------
  localparam int          PC_W       = 10;
  localparam logic [9:0]  VEC_PIN    = 10'h004;
  localparam logic [9:0]  VEC_TIMER  = 10'h008;

  // Phase-two pulses between acceptance and the jump.
  localparam logic [1:0]  WAIT_AWAKE = 2'h1;
  localparam logic [1:0]  WAIT_SLEEP = 2'h2;

  typedef enum logic [1:0] {
    TVI_IDLE,
    TVI_WAIT,
    TVI_CALL
  } tvi_state_t;

endpackage

// ===== rtl/tvi_edge_detect.sv
// Trigger-selectable edge detector for the external request pin.
`timescale 1ns/1ps
module tvi_edge_detect (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Pin and mode
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel,
  // Result
  output logic            edge_hit
);

  logic pin_prev_reg;
  logic pin_prev_next;
  logic rise;
  logic fall;

  always_comb begin
    pin_prev_next = pin_in;
    rise          = pin_in & ~pin_prev_reg;
    fall          = ~pin_in & pin_prev_reg;
    case (edge_sel)
      tvi_pkg::EDGE_RISING:  edge_hit = rise;
      tvi_pkg::EDGE_FALLING: edge_hit = fall;
      tvi_pkg::EDGE_BOTH:    edge_hit = rise | fall;
      default:               edge_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_prev_next;
    end
  end

endmodule

// ===== rtl/tvi_arbiter.sv
// Fixed-priority selection between the two enabled requests.
`timescale 1ns/1ps
module tvi_arbiter (
  // Requests
  input  wire logic        pin_req,
  input  wire logic        timer_req,
  // Selection
  output logic             grant_pin,
  output logic             grant_timer,
  output logic [9:0]       vector
);

  always_comb begin
    grant_pin   = pin_req;
    grant_timer = timer_req & ~pin_req;
    if (pin_req) begin
      vector = tvi_pkg::VEC_PIN;
    end else begin
      vector = tvi_pkg::VEC_TIMER;
    end
  end

endmodule

// ===== rtl/tvi_irq_unit.sv
// Top of the two-source vectored interrupt unit.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
// Behaviour
// - Global enable bit 0 gates all servicing
// - Timer request flag at bit 5, read/write
// - Pin request flag at bit 4, read/write
// - Timer enable at bit 2
// - Pin enable at bit 1
// - Bits 7, 6 and 3 read zero
// - Request raised only with source enable set
// - Accept: push next PC, jump to vector
// - Pin vector 04H, timer vector 08H
// - Pin beats timer when both pending
// - Acceptance clears global enable
// - Flags still set while servicing blocked
// - Re-set global enable allows nesting
// - No acceptance while stack full
// - Jump 2-3 cycles later, 3 from sleep
// - Requests sampled on phase-two pulse
// - Return-from-irq pops saved PC
// - Serviced source flag clears itself
// - Return-from-irq sets global enable; return not
// - Flag rising edge wakes from sleep
// - Two-bit pin trigger select field
module tvi_irq_unit (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register port
  input  wire logic [1:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Event sources
  input  wire logic                  ext_pin,
  input  wire logic                  timer_overflow,
  // Core sequencer and stack
  input  wire logic                  phase_two_pulse,
  input  wire logic                  stack_full,
  input  wire logic                  core_sleeping,
  input  wire logic [9:0]            next_pc,
  input  wire logic                  return_from_irq_instr,
  input  wire logic                  plain_return_instr,
  output logic                       push_req,
  output logic      [9:0]            push_pc,
  output logic                       jump_req,
  output logic      [9:0]            jump_addr,
  output logic                       pop_req,
  output logic                       wake_up,
  output logic                       irq_pending
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic bit_rise(input logic old_v, input logic new_v);
    bit_rise = new_v & ~old_v;
  endfunction

  // One write decode for both registers keeps their strobes consistent.
  function automatic logic wr_hit(input logic       wr,
                                  input logic [1:0] addr,
                                  input logic [1:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]           intc_reg;
  logic [7:0]           intc_next;
  logic [7:0]           sysctl2_reg;
  logic [7:0]           sysctl2_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  tvi_pkg::tvi_state_t  state_reg;
  tvi_pkg::tvi_state_t  state_next;
  logic [1:0]           wait_reg;
  logic [1:0]           wait_next;
  logic [9:0]           vec_reg;
  logic [9:0]           vec_next;
  logic                 push_reg;
  logic                 push_next;
  logic [9:0]           push_pc_reg;
  logic [9:0]           push_pc_next;
  logic                 jump_reg;
  logic                 jump_next;
  logic                 pop_reg;
  logic                 pop_next;
  logic                 wake_reg;
  logic                 wake_next;
  logic                 pend_reg;
  logic                 pend_next;

  // ---------------------------------------------------------------
  // Sources and arbitration
  // ---------------------------------------------------------------
  logic       pin_edge;
  logic       pin_req;
  logic       timer_req;
  logic       grant_pin;
  logic       grant_timer;
  logic [9:0] grant_vec;
  logic       accept;

  tvi_edge_detect u_edge (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   (ext_pin),
    .edge_sel (sysctl2_reg[tvi_pkg::BIT_EDGE_HIGH:tvi_pkg::BIT_EDGE_LOW]),
    .edge_hit (pin_edge)
  );

  // A flag only becomes a request while its own enable is set, whether
  // hardware or software put it there.
  assign pin_req   = intc_reg[tvi_pkg::BIT_PIN_FLAG]
                   & intc_reg[tvi_pkg::BIT_PIN_EN];
  assign timer_req = intc_reg[tvi_pkg::BIT_TIMER_FLAG]
                   & intc_reg[tvi_pkg::BIT_TIMER_EN];

  tvi_arbiter u_arb (
    .pin_req     (pin_req),
    .timer_req   (timer_req),
    .grant_pin   (grant_pin),
    .grant_timer (grant_timer),
    .vector      (grant_vec)
  );

  // Sampling only on the phase-two pulse means anything that arrived
  // since the previous pulse is taken together, so priority applies.
  assign accept = phase_two_pulse
                & (state_reg == tvi_pkg::TVI_IDLE)
                & intc_reg[tvi_pkg::BIT_GLOBAL_EN]
                & ~stack_full
                & (grant_pin | grant_timer);

  // ---------------------------------------------------------------
  // Control register and flags
  // ---------------------------------------------------------------
  // The order of the updates below is the priority between them: a
  // software write comes first, the return and the acceptance override
  // it, and the hardware events override everything. Software therefore
  // cannot lose a request by clearing a flag in the very cycle in which
  // the event arrives; it sees the flag again on its next read.
  // Unimplemented positions are masked on the way in, so they can never
  // hold a one that a later read would have to hide.
  always_comb begin
    intc_next    = intc_reg;
    sysctl2_next = sysctl2_reg;
    if (wr_hit(reg_wr, reg_addr, tvi_pkg::ADDR_INTC)) begin
      intc_next = reg_wdata & tvi_pkg::INTC_MASK;
    end
    if (wr_hit(reg_wr, reg_addr, tvi_pkg::ADDR_SYSCTL2)) begin
      sysctl2_next = reg_wdata & tvi_pkg::SYSCTL2_MASK;
    end
    if (return_from_irq_instr) begin
      intc_next[tvi_pkg::BIT_GLOBAL_EN] = 1'b1;
    end
    if (accept) begin
      intc_next[tvi_pkg::BIT_GLOBAL_EN] = 1'b0;
      if (grant_pin) begin
        intc_next[tvi_pkg::BIT_PIN_FLAG] = 1'b0;
      end else begin
        intc_next[tvi_pkg::BIT_TIMER_FLAG] = 1'b0;
      end
    end
    // Events come last so that a set in the same cycle as any clear wins.
    if (pin_edge) begin
      intc_next[tvi_pkg::BIT_PIN_FLAG] = 1'b1;
    end
    if (timer_overflow) begin
      intc_next[tvi_pkg::BIT_TIMER_FLAG] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Read data is zero outside the read slot, so the core may wire-or
  // this port with other peripherals without further gating.
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        tvi_pkg::ADDR_INTC:    rdata_next = intc_reg & tvi_pkg::INTC_MASK;
        tvi_pkg::ADDR_SYSCTL2: rdata_next = sysctl2_reg;
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Call sequencer
  // ---------------------------------------------------------------
  // Only one call is in flight at a time. A full stack stops the
  // acceptance itself rather than the push, so a pending flag is never
  // cleared for a call that could not be made; it simply waits for a
  // later phase-two pulse. The program counter is taken in the cycle of
  // the push so that the core sees the address it is about to fetch.
  always_comb begin
    state_next   = state_reg;
    wait_next    = wait_reg;
    vec_next     = vec_reg;
    push_next    = 1'b0;
    push_pc_next = push_pc_reg;
    jump_next    = 1'b0;
    case (state_reg)
      tvi_pkg::TVI_IDLE: begin
        if (accept) begin
          vec_next   = grant_vec;
          state_next = tvi_pkg::TVI_WAIT;
          // A sleeping core needs one more instruction cycle to restart.
          wait_next  = core_sleeping ? tvi_pkg::WAIT_SLEEP
                                     : tvi_pkg::WAIT_AWAKE;
        end
      end
      tvi_pkg::TVI_WAIT: begin
        if (phase_two_pulse) begin
          wait_next = wait_reg - 2'h1;
          if (wait_reg == 2'h1) begin
            state_next = tvi_pkg::TVI_CALL;
          end
        end
      end
      tvi_pkg::TVI_CALL: begin
        push_next    = 1'b1;
        push_pc_next = next_pc;
        jump_next    = 1'b1;
        state_next   = tvi_pkg::TVI_IDLE;
      end
      default: begin
        state_next = tvi_pkg::TVI_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Return, wake-up and status
  // ---------------------------------------------------------------
  always_comb begin
    pop_next  = return_from_irq_instr | plain_return_instr;
    // Enables play no part here: any flag going high wakes the core.
    wake_next = bit_rise(intc_reg[tvi_pkg::BIT_PIN_FLAG],
                         intc_next[tvi_pkg::BIT_PIN_FLAG])
              | bit_rise(intc_reg[tvi_pkg::BIT_TIMER_FLAG],
                         intc_next[tvi_pkg::BIT_TIMER_FLAG]);
    pend_next = (pin_req | timer_req)
              & intc_reg[tvi_pkg::BIT_GLOBAL_EN];
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Every output is a register, so the core sees no combinational path
  // from its own strobes back into its sequencer in the same cycle.
  // The price is one cycle of latency on each answer.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      intc_reg    <= tvi_pkg::INTC_RESET;
      sysctl2_reg <= tvi_pkg::SYSCTL2_RESET;
      rdata_reg   <= 8'h00;
      state_reg   <= tvi_pkg::TVI_IDLE;
      wait_reg    <= 2'h0;
      vec_reg     <= 10'h000;
      push_reg    <= 1'b0;
      push_pc_reg <= 10'h000;
      jump_reg    <= 1'b0;
      pop_reg     <= 1'b0;
      wake_reg    <= 1'b0;
      pend_reg    <= 1'b0;
    end else begin
      intc_reg    <= intc_next;
      sysctl2_reg <= sysctl2_next;
      rdata_reg   <= rdata_next;
      state_reg   <= state_next;
      wait_reg    <= wait_next;
      vec_reg     <= vec_next;
      push_reg    <= push_next;
      push_pc_reg <= push_pc_next;
      jump_reg    <= jump_next;
      pop_reg     <= pop_next;
      wake_reg    <= wake_next;
      pend_reg    <= pend_next;
    end
  end

  assign reg_rdata   = rdata_reg;
  assign push_req    = push_reg;
  assign push_pc     = push_pc_reg;
  assign jump_req    = jump_reg;
  assign jump_addr   = vec_reg;
  assign pop_req     = pop_reg;
  assign wake_up     = wake_reg;
  assign irq_pending = pend_reg;

endmodule

// ===== testbench/tvi_irq_unit_chk.sv
// Assertion checker bound to the interrupt unit top.
`timescale 1ns/1ps
module tvi_irq_unit_chk (
  // Clock, reset and register port
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [1:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core side
  input wire logic       phase_two_pulse,
  input wire logic       return_from_irq_instr,
  input wire logic       plain_return_instr,
  input wire logic       push_req,
  input wire logic       jump_req,
  input wire logic [9:0] jump_addr,
  input wire logic       pop_req,
  input wire logic       irq_pending
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence rd_intc_s; reg_rd && reg_addr == tvi_pkg::ADDR_INTC; endsequence
  sequence ret_s; return_from_irq_instr || plain_return_instr; endsequence
  call_pair_a: assert property (push_req == jump_req)
    else $error("push and jump not paired");
  vector_value_a: assert property (jump_req |->
    jump_addr == 10'h004 || jump_addr == 10'h008)
    else $error("jump address not a vector");
  pop_after_ret_a: assert property (ret_s |=> pop_req)
    else $error("return without pop");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  rsvd_zero_a: assert property (rd_intc_s |=> (reg_rdata & 8'hc8) == 0)
    else $error("reserved bits read nonzero");
  unmapped_zero_a: assert property (reg_rd && reg_addr[1] |=>
    reg_rdata == 8'h00) else $error("unmapped read nonzero");
  call_masked_a: assert property (push_req |-> !irq_pending)
    else $error("global enable still set at call");
  pulse_lead_a: assert property (push_req |->
    $past(phase_two_pulse, 2)) else $error("call not on phase pulse");
endmodule
bind tvi_irq_unit tvi_irq_unit_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .phase_two_pulse(phase_two_pulse),
  .return_from_irq_instr(return_from_irq_instr),
  .plain_return_instr(plain_return_instr), .push_req(push_req),
  .jump_req(jump_req), .jump_addr(jump_addr), .pop_req(pop_req),
  .irq_pending(irq_pending));

// ===== testbench/tvi_core_model.sv
// Model of the core sequencer, program counter and stack.
`timescale 1ns/1ps
module tvi_core_model #(
  parameter int DEPTH = 1
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Stack requests
  input  wire logic       push_req,
  input  wire logic       pop_req,
  // Sequencer view
  output logic            phase_two_pulse,
  output logic [9:0]      next_pc,
  output logic            stack_full
);
  // A shallow stack makes the full condition easy to reach.
  logic [1:0] phase_reg;
  int         depth_reg;
  assign phase_two_pulse = (phase_reg == 2'h3);
  assign stack_full = (depth_reg >= DEPTH);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= 2'h0;
      next_pc <= 10'h020;
      depth_reg <= 0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      next_pc <= next_pc + 10'h001;
      if (push_req)
        depth_reg <= depth_reg + 1;
      else if (pop_req && depth_reg > 0)
        depth_reg <= depth_reg - 1;
    end
  end
endmodule

// ===== testbench/test_tvi_irq_unit.sv
// Self-checking testbench of the two-source vectored interrupt unit.
`timescale 1ns/1ps
module test_tvi_irq_unit;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, ext_pin = 1'b0;
  logic       timer_overflow = 1'b0, core_sleeping = 1'b0;
  logic       return_from_irq_instr = 1'b0, plain_return_instr = 1'b0;
  logic [7:0] reg_rdata, v;
  logic       phase_two_pulse, stack_full, push_req, jump_req, pop_req;
  logic       wake_up, irq_pending;
  logic [9:0] next_pc, push_pc, jump_addr;
  int         n_errors = 0;
  int         checks_done = 0;
  int         m;
  always #20 clk_sys = ~clk_sys;
  tvi_irq_unit dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_pin(ext_pin),
    .timer_overflow(timer_overflow), .phase_two_pulse(phase_two_pulse),
    .stack_full(stack_full), .core_sleeping(core_sleeping),
    .next_pc(next_pc), .return_from_irq_instr(return_from_irq_instr),
    .plain_return_instr(plain_return_instr), .push_req(push_req),
    .push_pc(push_pc), .jump_req(jump_req), .jump_addr(jump_addr),
    .pop_req(pop_req), .wake_up(wake_up), .irq_pending(irq_pending));
  tvi_core_model core (.clk_sys(clk_sys), .rst(rst), .push_req(push_req),
    .pop_req(pop_req), .phase_two_pulse(phase_two_pulse),
    .next_pc(next_pc), .stack_full(stack_full));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_intc(input logic [7:0] w);
    return w & 8'h37;
  endfunction
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk({2'h0, reg_rdata}, {2'h0, e});
  endtask
  // Kind 0 is a timer overflow, 1 a return-from-irq, 2 a plain return.
  task automatic ev(input int k);
    @(posedge clk_sys);
    timer_overflow <= (k == 0);
    return_from_irq_instr <= (k == 1);
    plain_return_instr <= (k == 2);
    @(posedge clk_sys);
    timer_overflow <= 1'b0;
    return_from_irq_instr <= 1'b0;
    plain_return_instr <= 1'b0;
    #1;
  endtask
  task automatic set_pin(input logic p);
    @(posedge clk_sys);
    ext_pin <= p;
  endtask
  // Counts phase pulses before the call; a negative count skips that check.
  task automatic wait_call(input logic [9:0] vec, input int np);
    int n;
    int t;
    logic [9:0] pc;
    n = 0;
    t = 0;
    pc = 10'h000;
    #1;
    while (push_req !== 1'b1 && t < 200) begin
      n += int'(phase_two_pulse === 1'b1);
      pc = next_pc;
      @(posedge clk_sys);
      #1;
      t++;
    end
    chk({9'h0, jump_req}, 10'h001);
    chk(jump_addr, vec);
    chk(push_pc, pc);
    if (np >= 0) chk(10'(n), 10'(np));
  endtask
  task automatic quiet(input int cycles);
    int cnt;
    cnt = 0;
    repeat (cycles) begin
      @(posedge clk_sys);
      #1;
      cnt += int'(push_req === 1'b1);
    end
    chk(10'(cnt), 10'h000);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h4a9b6f49));
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(tvi_pkg::ADDR_INTC, tvi_pkg::INTC_RESET);
    rd(tvi_pkg::ADDR_SYSCTL2, tvi_pkg::SYSCTL2_RESET);
    wr(tvi_pkg::ADDR_INTC, 8'hfe);
    rd(tvi_pkg::ADDR_INTC, 8'h36);
    repeat (8) begin
      v = 8'($urandom) & 8'hfe;
      wr(tvi_pkg::ADDR_INTC, v);
      rd(tvi_pkg::ADDR_INTC, exp_intc(v));
      wr(tvi_pkg::ADDR_SYSCTL2, v);
      rd(tvi_pkg::ADDR_SYSCTL2, v & 8'hc0);
      wr({1'b1, v[0]}, v);
      rd({1'b1, v[0]}, 8'h00);
    end
    wr(tvi_pkg::ADDR_INTC, 8'h00);
    for (m = 0; m < 4; m++) begin
      wr(tvi_pkg::ADDR_SYSCTL2, {m[1:0], 6'h00});
      set_pin(1'b1);
      rd(tvi_pkg::ADDR_INTC, {3'h0, m[0], 4'h0});
      wr(tvi_pkg::ADDR_INTC, 8'h00);
      set_pin(1'b0);
      rd(tvi_pkg::ADDR_INTC, {3'h0, m[1], 4'h0});
      wr(tvi_pkg::ADDR_INTC, 8'h00);
    end
    wr(tvi_pkg::ADDR_SYSCTL2, 8'h00);
    wr(tvi_pkg::ADDR_INTC, 8'h01);
    ev(0);
    chk({9'h0, wake_up}, 10'h001);
    rd(tvi_pkg::ADDR_INTC, 8'h21);
    ev(0);
    chk({9'h0, wake_up}, 10'h000);
    quiet(24);
    wr(tvi_pkg::ADDR_INTC, 8'h24);
    quiet(24);
    wr(tvi_pkg::ADDR_INTC, 8'h25);
    wait_call(tvi_pkg::VEC_TIMER, 2);
    rd(tvi_pkg::ADDR_INTC, 8'h04);
    ev(1);
    chk({9'h0, pop_req}, 10'h001);
    rd(tvi_pkg::ADDR_INTC, 8'h05);
    wr(tvi_pkg::ADDR_INTC, 8'h37);
    wait_call(tvi_pkg::VEC_PIN, 2);
    rd(tvi_pkg::ADDR_INTC, 8'h26);
    wr(tvi_pkg::ADDR_INTC, 8'h27);
    quiet(24);
    ev(2);
    chk({9'h0, pop_req}, 10'h001);
    wait_call(tvi_pkg::VEC_TIMER, -1);
    rd(tvi_pkg::ADDR_INTC, 8'h06);
    ev(2);
    rd(tvi_pkg::ADDR_INTC, 8'h06);
    ev(1);
    rd(tvi_pkg::ADDR_INTC, 8'h07);
    @(posedge clk_sys);
    core_sleeping <= 1'b1;
    wr(tvi_pkg::ADDR_INTC, 8'h25);
    wait_call(tvi_pkg::VEC_TIMER, 3);
    core_sleeping <= 1'b0;
    ev(1);
    print_verdict;
  end
endmodule
